//--- include/rxo_pkg.sv
package rxo_pkg;

    // register map, byte addresses of aligned words
    localparam logic [31:0] CTRL_ADDR       = 32'h0000_0000;
    localparam logic [31:0] STATUS_ADDR     = 32'h0000_0004;
    localparam logic [31:0] ADDR_MASK       = 32'h0000_00ff;

    // control fields
    localparam int          CTRL_MODE_LSB   = 0;
    localparam int          CTRL_CTC_BIT    = 2;
    localparam int          CTRL_CODE_BIT   = 3;
    localparam logic [31:0] CTRL_RST        = 32'h0000_000c;
    localparam logic [31:0] CTRL_WMASK      = 32'h0000_000f;

    // status fields
    localparam int          STAT_MODE_LSB   = 0;
    localparam int          STAT_CTC_BIT    = 2;
    localparam int          STAT_CODE_BIT   = 3;
    localparam int          STAT_SEEN_BIT   = 4;
    localparam int          STAT_CNT_LSB    = 16;

    // interface mode field encodings
    localparam logic [1:0]  MODE_NIBBLE     = 2'h0;
    localparam logic [1:0]  MODE_MUX        = 2'h1;
    localparam logic [1:0]  MODE_INDEP      = 2'h2;

    // lane widths
    localparam int          LANE_W          = 10;
    localparam int          HALF_W          = 5;
    localparam int          NCHAN_CLK       = 7;

    // ahb encodings
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ      = 2'h3;
    localparam logic        HRESP_OKAY      = 1'b0;

    typedef enum logic [1:0] {
        RXO_NIBBLE,
        RXO_MUX,
        RXO_INDEP
    } rxo_mode_type;

endpackage

//--- rtl/rxo_sync2.sv
`timescale 1ns/1ps

module rxo_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] stable_r;

    // first stage is read only by the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r   <= '0;
            stable_r <= '0;
        end else begin
            meta_r   <= async_in;
            stable_r <= meta_r;
        end
    end

    assign sync_out = stable_r;

endmodule // rxo_sync2

//--- rtl/rxo_lane.sv
// How it works
// - multiplexed and independent modes: common clock is the buffered reference clock.
// - compensation off: common clock is recovered clock over ten; on: reference.
// - compensation may be switched off only in nibble mode.
// - independent mode: each channel A..G gets its own recovered clock.
// - nibble, compensation off: channel clocks recovered over ten; else reference copies.
// - multiplexed mode: A,C,E,G are the inverted common clock; B,D,F copy the common clock.
// - lane outputs change on both rising and falling receive clock edges.
// - multiplexed mode: channel B on rising edge, channel A on falling edge.
// - nibble mode: low nibble falling, high nibble rising; A on [4:0], B on [9:5].
// - nibble mode with decoding: bit 3 is channel A K-flag in rising phase.
// - multiplexed mode: bit 8 is word bit 9 raw, or K-flag when decoded.
// - nibble mode: bit 8 is B bits 4 and 9 raw; decoded, bit 4 then K-flag.
// - raw: bit 9 is tenth bit multiplexed, B bits 5 and 10 in nibble mode.
`timescale 1ns/1ps

module rxo_lane (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        rx_phase_clk,
    input  wire logic [9:0]  chan_a_word,
    input  wire logic [9:0]  chan_b_word,
    input  wire logic        chan_a_kflag,
    input  wire logic        chan_b_kflag,
    input  wire logic [6:0]  chan_rec_clk_div,
    output logic      [9:0]  rx_lane_ab_word,
    output logic             rx_chan_h_clk,
    output logic      [6:0]  rx_chan_clk_bus,
    output logic             reference_clk_sel
);

    ////////////////////////////////////////////////////////////////////////////////
    // bus side declarations

    logic [31:0] ctrl_r;
    logic        wr_pend_r;
    logic [31:0] wr_addr_r;
    logic [31:0] hrdata_r;
    logic        hreadyout_r;
    logic        hresp_r;
    logic        ref_sel_r;
    logic        seen_r;
    logic [15:0] word_cnt_r;
    logic        beat_d_r;
    logic        beat_h;
    logic        beat_edge;
    logic        addr_phase;
    logic [31:0] addr_off;
    logic [31:0] status_val;
    logic [1:0]  mode_raw;
    logic [1:0]  mode_eff;
    logic        ctc_eff;
    logic        code_en;
    logic        seen_clr;

    ////////////////////////////////////////////////////////////////////////////////
    // link side declarations

    logic [1:0]  lrst_r;
    logic        link_rst_n;
    logic [3:0]  cfg_l;
    logic [1:0]  lmode;
    logic        lctc;
    logic        lcode;
    logic [6:0]  rec_clk_l;
    logic        clk_lvl_r;
    logic [9:0]  a_hold_r;
    logic [9:0]  b_hold_r;
    logic        ka_hold_r;
    logic        kb_hold_r;
    logic [9:0]  lane_r;
    logic [9:0]  lane_nxt;
    logic [6:0]  chan_clk_r;
    logic [6:0]  chan_clk_nxt;
    logic        beat_r;
    logic        rising_phase;
    logic [9:0]  a_src;
    logic [9:0]  b_src;
    logic        ka_src;
    logic        kb_src;

    ////////////////////////////////////////////////////////////////////////////////
    // effective configuration

    assign mode_raw = ctrl_r[rxo_pkg::CTRL_MODE_LSB +: 2];
    assign code_en  = ctrl_r[rxo_pkg::CTRL_CODE_BIT];
    // reserved mode code falls back to nibble
    assign mode_eff = (mode_raw == rxo_pkg::MODE_MUX || mode_raw == rxo_pkg::MODE_INDEP)
                      ? mode_raw : rxo_pkg::MODE_NIBBLE;
    // compensation forced on outside nibble mode
    assign ctc_eff  = ctrl_r[rxo_pkg::CTRL_CTC_BIT] | (mode_eff != rxo_pkg::MODE_NIBBLE);

    ////////////////////////////////////////////////////////////////////////////////
    // ahb-lite slave, zero wait states

    assign addr_phase = hsel & hready & (htrans == rxo_pkg::HTRANS_NONSEQ || htrans == rxo_pkg::HTRANS_SEQ);
    assign addr_off   = haddr & rxo_pkg::ADDR_MASK;
    assign seen_clr   = wr_pend_r & (wr_addr_r == rxo_pkg::STATUS_ADDR) & hwdata[rxo_pkg::STAT_SEEN_BIT];

    always_comb begin
        status_val = '0;
        status_val[rxo_pkg::STAT_MODE_LSB +: 2] = mode_eff;
        status_val[rxo_pkg::STAT_CTC_BIT]       = ctc_eff;
        status_val[rxo_pkg::STAT_CODE_BIT]      = code_en;
        status_val[rxo_pkg::STAT_SEEN_BIT]      = seen_r;
        status_val[rxo_pkg::STAT_CNT_LSB +: 16] = word_cnt_r;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= '0;
        end else begin
            wr_pend_r <= addr_phase & hwrite;
            wr_addr_r <= addr_off;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= '0;
        end else if (addr_phase && !hwrite) begin
            case (addr_off)
                rxo_pkg::CTRL_ADDR:   hrdata_r <= ctrl_r;
                rxo_pkg::STATUS_ADDR: hrdata_r <= status_val;
                default:              hrdata_r <= '0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= rxo_pkg::CTRL_RST;
        end else if (wr_pend_r && wr_addr_r == rxo_pkg::CTRL_ADDR) begin
            ctrl_r <= hwdata & rxo_pkg::CTRL_WMASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_r <= 1'b1;
            hresp_r     <= rxo_pkg::HRESP_OKAY;
        end else begin
            hreadyout_r <= 1'b1;
            hresp_r     <= rxo_pkg::HRESP_OKAY;
        end
    end

    // tells the outside clock selector what drives rx_phase_clk
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_sel_r <= 1'b1;
        end else begin
            ref_sel_r <= ctc_eff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // link activity seen from the bus side

    rxo_sync2 #(.WIDTH(1)) u_beat_sync (
        .clk      (hclk),
        .rst_n    (hresetn),
        .async_in (beat_r),
        .sync_out (beat_h)
    );

    assign beat_edge = beat_h ^ beat_d_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            beat_d_r   <= 1'b0;
            word_cnt_r <= '0;
        end else begin
            beat_d_r <= beat_h;
            if (beat_edge) begin
                word_cnt_r <= word_cnt_r + 16'h0001;
            end
        end
    end

    // a new word wins over a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seen_r <= 1'b0;
        end else if (beat_edge) begin
            seen_r <= 1'b1;
        end else if (seen_clr) begin
            seen_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // link domain reset and configuration crossing

    always_ff @(posedge rx_phase_clk or negedge hresetn) begin
        if (!hresetn) begin
            lrst_r <= 2'h0;
        end else begin
            lrst_r <= {lrst_r[0], 1'b1};
        end
    end

    assign link_rst_n = lrst_r[1];

    // configuration is quasi-static; change it only while the link is idle
    rxo_sync2 #(.WIDTH(4)) u_cfg_sync (
        .clk      (rx_phase_clk),
        .rst_n    (link_rst_n),
        .async_in ({code_en, ctc_eff, mode_eff}),
        .sync_out (cfg_l)
    );

    assign lmode = cfg_l[1:0];
    assign lctc  = cfg_l[2];
    assign lcode = cfg_l[3];

    rxo_sync2 #(.WIDTH(rxo_pkg::NCHAN_CLK)) u_rec_sync (
        .clk      (rx_phase_clk),
        .rst_n    (link_rst_n),
        .async_in (chan_rec_clk_div),
        .sync_out (rec_clk_l)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // ddr sequencing: one phase clock cycle per receive clock edge

    // next edge of the common clock is rising when the level is low now
    assign rising_phase = ~clk_lvl_r;

    always_ff @(posedge rx_phase_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            clk_lvl_r <= 1'b0;
        end else begin
            clk_lvl_r <= ~clk_lvl_r;
        end
    end

    // words are taken at each falling phase and held for the rising phase
    always_ff @(posedge rx_phase_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            a_hold_r  <= '0;
            b_hold_r  <= '0;
            ka_hold_r <= 1'b0;
            kb_hold_r <= 1'b0;
            beat_r    <= 1'b0;
        end else if (!rising_phase) begin
            a_hold_r  <= chan_a_word;
            b_hold_r  <= chan_b_word;
            ka_hold_r <= chan_a_kflag;
            kb_hold_r <= chan_b_kflag;
            beat_r    <= ~beat_r;
        end
    end

    // falling phase presents the fresh words, rising phase the held ones
    assign a_src  = rising_phase ? a_hold_r  : chan_a_word;
    assign b_src  = rising_phase ? b_hold_r  : chan_b_word;
    assign ka_src = rising_phase ? ka_hold_r : chan_a_kflag;
    assign kb_src = rising_phase ? kb_hold_r : chan_b_kflag;

    always_comb begin
        lane_nxt = '0;
        case (lmode)
            rxo_pkg::MODE_NIBBLE: begin
                if (!lcode) begin
                    if (rising_phase) begin
                        lane_nxt[4:0] = a_src[9:5];
                        lane_nxt[9:5] = b_src[9:5];
                    end else begin
                        lane_nxt[4:0] = a_src[4:0];
                        lane_nxt[9:5] = b_src[4:0];
                    end
                end else begin
                    if (rising_phase) begin
                        lane_nxt[2:0] = a_src[7:5];
                        lane_nxt[3]   = ka_src;
                        lane_nxt[7:5] = b_src[7:5];
                        lane_nxt[8]   = kb_src;
                    end else begin
                        lane_nxt[4:0] = a_src[4:0];
                        lane_nxt[9:5] = b_src[4:0];
                    end
                end
            end
            rxo_pkg::MODE_MUX, rxo_pkg::MODE_INDEP: begin
                if (rising_phase) begin
                    lane_nxt = lcode ? {1'b0, kb_src, b_src[7:0]} : b_src;
                end else begin
                    lane_nxt = lcode ? {1'b0, ka_src, a_src[7:0]} : a_src;
                end
            end
            default: begin
                lane_nxt = '0;
            end
        endcase
    end

    // lane and clocks change on the same phase edge, so data sits on both clock edges
    always_ff @(posedge rx_phase_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            lane_r <= '0;
        end else begin
            lane_r <= lane_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // per-channel clock outputs

    genvar ch;
    generate
        for (ch = 0; ch < rxo_pkg::NCHAN_CLK; ch++) begin : g_chan_clk
            always_comb begin
                chan_clk_nxt[ch] = rising_phase;
                case (lmode)
                    rxo_pkg::MODE_MUX: begin
                        // even slots A,C,E,G invert, odd slots B,D,F copy
                        chan_clk_nxt[ch] = (ch % 2 == 0) ? ~rising_phase : rising_phase;
                    end
                    rxo_pkg::MODE_INDEP: begin
                        chan_clk_nxt[ch] = rec_clk_l[ch];
                    end
                    rxo_pkg::MODE_NIBBLE: begin
                        chan_clk_nxt[ch] = lctc ? rising_phase : rec_clk_l[ch];
                    end
                    default: begin
                        chan_clk_nxt[ch] = rising_phase;
                    end
                endcase
            end
        end
    endgenerate

    always_ff @(posedge rx_phase_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            chan_clk_r <= '0;
        end else begin
            chan_clk_r <= chan_clk_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign hrdata            = hrdata_r;
    assign hreadyout         = hreadyout_r;
    assign hresp             = hresp_r;
    assign rx_lane_ab_word   = lane_r;
    assign rx_chan_h_clk     = clk_lvl_r;
    assign rx_chan_clk_bus   = chan_clk_r;
    assign reference_clk_sel = ref_sel_r;

endmodule // rxo_lane

//--- sim/rxo_lane_sva.sv
`timescale 1ns/1ps

module rxo_lane_sva (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        rx_phase_clk,
    input wire logic [9:0]  chan_a_word,
    input wire logic [9:0]  chan_b_word,
    input wire logic        chan_a_kflag,
    input wire logic        chan_b_kflag,
    input wire logic [6:0]  chan_rec_clk_div,
    input wire logic [9:0]  rx_lane_ab_word,
    input wire logic        rx_chan_h_clk,
    input wire logic [6:0]  rx_chan_clk_bus,
    input wire logic        reference_clk_sel
);
    logic [3:0] cfg_r, cfg_l;
    logic       wr_p;
    logic [2:0] st_l;
    logic [9:0] a1, b1, a2, b2;
    logic       ka1, kb1, ka2, kb2;
    // shadow of the control word, snooped off the bus
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_r <= rxo_pkg::CTRL_RST[3:0];
            wr_p  <= 1'b0;
        end else begin
            wr_p <= hsel && hready && htrans[1] && hwrite && ((haddr & rxo_pkg::ADDR_MASK) == rxo_pkg::CTRL_ADDR);
            if (wr_p) cfg_r <= hwdata[3:0];
        end
    end
    // settle count: lane checks wait out the crossing after any change
    always_ff @(posedge rx_phase_clk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_l <= rxo_pkg::CTRL_RST[3:0];
            st_l  <= 3'h0;
        end else begin
            cfg_l <= cfg_r;
            if (cfg_l != cfg_r) st_l <= 3'h0;
            else if (st_l != 3'h7) st_l <= st_l + 3'h1;
        end
    end
    always_ff @(posedge rx_phase_clk) begin
        {ka1, kb1, a1, b1} <= {chan_a_kflag, chan_b_kflag, chan_a_word, chan_b_word};
        {ka2, kb2, a2, b2} <= {ka1, kb1, a1, b1};
    end
    wire [1:0] ml   = (cfg_l[1:0] == 2'h3) ? rxo_pkg::MODE_NIBBLE : cfg_l[1:0];
    wire       nib  = ml == rxo_pkg::MODE_NIBBLE;
    wire       comp = cfg_l[2] | !nib;
    wire       cd   = cfg_l[3];
    wire       ok   = st_l == 3'h7;
    wire [9:0] fa   = cd ? {1'b0, ka1, a1[7:0]} : a1;
    wire [9:0] rb   = cd ? {1'b0, kb2, b2[7:0]} : b2;
    wire [9:0] nr   = cd ? {1'b0, kb2, b2[7:5], 1'b0, ka2, a2[7:5]} : {b2[9:5], a2[9:5]};
    ////////////////////////////////////////////////////////////
    a_clk_toggle: assert property (@(posedge rx_phase_clk) disable iff (!hresetn)
        ok |-> rx_chan_h_clk != $past(rx_chan_h_clk)) else $error("receive clock missed an edge");
    a_mux_fall: assert property (@(posedge rx_phase_clk) disable iff (!hresetn)
        ok && !nib && $fell(rx_chan_h_clk) |-> rx_lane_ab_word == fa) else $error("falling half not chan a");
    // both halves must fall inside one settled configuration
    a_mux_rise: assert property (@(posedge rx_phase_clk) disable iff (!hresetn)
        ok && !nib && $fell(rx_chan_h_clk) ##1 ok |-> rx_lane_ab_word == rb) else $error("rising half not chan b");
    a_nib_fall: assert property (@(posedge rx_phase_clk) disable iff (!hresetn)
        ok && nib && $fell(rx_chan_h_clk) |-> rx_lane_ab_word == {b1[4:0], a1[4:0]}) else $error("low nibbles wrong");
    a_nib_rise: assert property (@(posedge rx_phase_clk) disable iff (!hresetn)
        ok && nib && $fell(rx_chan_h_clk) ##1 ok |-> rx_lane_ab_word == nr) else $error("high nibbles wrong");
    a_mux_clocks: assert property (@(posedge rx_phase_clk) disable iff (!hresetn)
        ok && ml == rxo_pkg::MODE_MUX |-> rx_chan_clk_bus == {{3{~rx_chan_h_clk, rx_chan_h_clk}}, ~rx_chan_h_clk})
        else $error("paired clock copies wrong");
    a_ref_copies: assert property (@(posedge rx_phase_clk) disable iff (!hresetn)
        ok && nib && comp |-> rx_chan_clk_bus == {7{rx_chan_h_clk}}) else $error("channel clocks not reference");
    a_rec_clocks: assert property (@(posedge rx_phase_clk) disable iff (!hresetn)
        ok && (ml == rxo_pkg::MODE_INDEP || !comp) |-> rx_chan_clk_bus == $past(chan_rec_clk_div, 3))
        else $error("channel clocks not recovered");
    // select output lives on the bus clock; skip the link edge that first sees a new control word
    a_ref_select: assert property (@(posedge rx_phase_clk) disable iff (!hresetn)
        ok && cfg_l == cfg_r |-> reference_clk_sel == comp) else $error("clock source select wrong");
endmodule // rxo_lane_sva

bind rxo_lane rxo_lane_sva u_sva (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .rx_phase_clk, .chan_a_word, .chan_b_word, .chan_a_kflag, .chan_b_kflag, .chan_rec_clk_div,
    .rx_lane_ab_word, .rx_chan_h_clk, .rx_chan_clk_bus, .reference_clk_sel);

//--- sim/rxo_partner.sv
`timescale 1ns/1ps

module rxo_partner (
    input  wire logic        rx_phase_clk,
    input  wire logic        nibble,
    input  wire logic        code,
    input  wire logic        clk_h,
    input  wire logic [9:0]  lane,
    output logic      [10:0] got_a,
    output logic      [10:0] got_b
);
    logic [9:0] fall_r;
    // falling half is latched; rising half is read live at the next edge
    always_ff @(posedge rx_phase_clk) begin
        if (!clk_h) fall_r <= lane;
    end
    always_comb begin
        if (nibble && code) begin
            got_a = {lane[3], 2'h0, lane[2:0], fall_r[4:0]};
            got_b = {lane[8], 2'h0, lane[7:5], fall_r[9:5]};
        end else if (nibble) begin
            got_a = {1'b0, lane[4:0], fall_r[4:0]};
            got_b = {1'b0, lane[9:5], fall_r[9:5]};
        end else begin
            got_a = code ? {fall_r[8], 2'h0, fall_r[7:0]} : {1'b0, fall_r};
            got_b = code ? {lane[8], 2'h0, lane[7:0]} : {1'b0, lane};
        end
    end
endmodule // rxo_partner

//--- sim/rxo_lane_tb.sv
`timescale 1ns/1ps

module rxo_lane_tb;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, r, e, x;
    logic        hreadyout, hresp, rx_chan_h_clk, reference_clk_sel;
    logic        rx_phase_clk = 1'b0;
    logic [9:0]  chan_a_word = 10'h0;
    logic [9:0]  chan_b_word = 10'h0;
    logic        chan_a_kflag = 1'b0;
    logic        chan_b_kflag = 1'b0;
    logic [6:0]  chan_rec_clk_div = 7'h0;
    logic [9:0]  rx_lane_ab_word;
    logic [6:0]  rx_chan_clk_bus;
    logic [10:0] got_a, got_b, ea, eb;
    logic        nib = 1'b1;
    logic        code = 1'b1;
    logic        lane_on = 1'b0;
    logic        have = 1'b0;
    logic [31:0] seed = 32'hf629;
    int          miscompares = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    logic [3:0]  cfg_t [8] = '{4'h0, 4'h8, 4'h4, 4'hc, 4'h1, 4'h9, 4'ha, 4'hb};

    rxo_lane uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .rx_phase_clk, .chan_a_word, .chan_b_word, .chan_a_kflag, .chan_b_kflag,
        .chan_rec_clk_div, .rx_lane_ab_word, .rx_chan_h_clk, .rx_chan_clk_bus, .reference_clk_sel);
    rxo_partner u_far (.rx_phase_clk, .nibble(nib), .code, .clk_h(rx_chan_h_clk), .lane(rx_lane_ab_word),
        .got_a, .got_b);

    always #20 hclk = ~hclk;
    // odd offset keeps link edges clear of bus edges
    initial begin
        #13;
        forever #80 rx_phase_clk = ~rx_phase_clk;
    end
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [10:0] ex(input logic [9:0] w, input logic k);
        return code ? {k, 2'h0, w[7:0]} : {1'b0, w};
    endfunction
    function automatic logic [31:0] stat_exp(input logic [3:0] c);
        logic [1:0] m;
        m = (c[1:0] == 2'h3) ? rxo_pkg::MODE_NIBBLE : c[1:0];
        return {28'h0, c[3], c[2] | (m != rxo_pkg::MODE_NIBBLE), m};
    endfunction
    task automatic chk(input string nm, input logic [31:0] ex_v, input logic [31:0] got);
        samples_checked++;
        if (got !== ex_v) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, ex_v, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= rxo_pkg::HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic close_out();
        $display("checked %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // words change only in the phase before a sampling edge
    always @(posedge rx_phase_clk) begin
        x = rnd();
        if (x[31:28] == 4'h0) x[21:0] = 22'h3fffff;
        chan_rec_clk_div <= x[28:22];
        if (rx_chan_h_clk === 1'b1) begin
            if (lane_on && have) begin
                chk("lane chan a", {21'h0, ea}, {21'h0, got_a});
                chk("lane chan b", {21'h0, eb}, {21'h0, got_b});
            end
            have <= lane_on;
            ea <= ex(chan_a_word, chan_a_kflag);
            eb <= ex(chan_b_word, chan_b_kflag);
        end else begin
            {chan_a_kflag, chan_b_kflag, chan_a_word, chan_b_word} <= x[21:0];
        end
    end
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            close_out();
        end
    end
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, rxo_pkg::CTRL_ADDR, 32'h0, r);
        chk("ctrl reset", rxo_pkg::CTRL_RST, r);
        bus(1'b0, 32'h0000_0010, 32'h0, r);
        chk("unmapped read", 32'h0, r);
        bus(1'b1, rxo_pkg::STATUS_ADDR, 32'h0000_000f, r);
        for (int i = 0; i < 8; i++) begin
            lane_on <= 1'b0;
            e = stat_exp(cfg_t[i]);
            // non-blocking, so the partner's format cannot flip under a compare on this edge
            nib <= e[1:0] == rxo_pkg::MODE_NIBBLE;
            code <= e[3];
            bus(1'b1, rxo_pkg::CTRL_ADDR, {28'h0, cfg_t[i]}, r);
            bus(1'b0, rxo_pkg::STATUS_ADDR, 32'h0, r);
            chk("status", e, r & 32'h0000_000f);
            repeat (12) @(posedge rx_phase_clk);
            chk("ref select", {31'h0, e[2]}, {31'h0, reference_clk_sel});
            lane_on <= 1'b1;
            repeat (40) @(posedge rx_phase_clk);
        end
        close_out();
    end
endmodule // rxo_lane_tb
